// [rtl/drive_pulse_timer.sv]
// Purpose: Gate drive flop with on-time count, short blanking and max on-time
// Assumes: start only while drive is low
// Notes: Drive stays high exactly MAX_ON_CYC cycles unless killed
`include "fault_sup_params.svh"
`timescale 1ns/1ps
`default_nettype none
module drive_pulse_timer (
   input wire logic clk_sys,
   input wire logic rst,
   pulse_if.drv pif
);
   localparam logic [`ON_CNT_W-1:0] ON_TOP = `ON_CNT_W'(`MAX_ON_CYC - 1);
   localparam logic [`ON_CNT_W-1:0] BLANK = `ON_CNT_W'(`SHORT_BLANK_CYC);

   logic drive_ff;
   logic [`ON_CNT_W-1:0] on_cnt_ff;
   logic nxt_drive;
   logic [`ON_CNT_W-1:0] nxt_on_cnt;
   wire at_max = drive_ff & (on_cnt_ff == ON_TOP);

   assign nxt_drive = pif.kill ? 1'b0 : (pif.start | (drive_ff & ~at_max));
   assign nxt_on_cnt = pif.start ? '0 : (drive_ff ? on_cnt_ff + 1'b1 : on_cnt_ff);
   assign pif.drive = drive_ff;
   assign pif.blank_done = drive_ff & (on_cnt_ff >= BLANK);
   assign pif.pulse_end = drive_ff & ~nxt_drive;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         drive_ff <= 1'b0;
         on_cnt_ff <= '0;
      end else begin
         drive_ff <= nxt_drive;
         on_cnt_ff <= nxt_on_cnt;
      end
   end

   a_max_on_end: assert property (@(posedge clk_sys) disable iff (rst)
      at_max |=> !drive_ff)
      else $error("drive pulse exceeded max on-time");
   a_short_blank: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(drive_ff) |-> !pif.blank_done [*7])
      else $error("abnormal comparator unblanked too early");
endmodule : drive_pulse_timer
`default_nettype wire

// [rtl/fault_sup_params.svh]
// Purpose: Timing constants for the flyback fault supervisor
// Assumes: 50 MHz system clock
// Notes: Least times round up, longest times round down
`ifndef FAULT_SUP_PARAMS_SVH
`define FAULT_SUP_PARAMS_SVH

`define CLK_PERIOD_NS 20
// Blanking after turn-on, a least time
`define SHORT_BLANK_NS 125
`define SHORT_BLANK_CYC ((`SHORT_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Longest drive pulse
`define MAX_ON_US 32
`define MAX_ON_CYC ((`MAX_ON_US * 1000) / `CLK_PERIOD_NS)
`define ON_CNT_W 11
// Overload integrator full scale
`define OVLD_MS 160
`define OVLD_CYC ((`OVLD_MS * 1000000) / `CLK_PERIOD_NS)
// Auto-recovery wait, 1.2 s held in ms
`define AUTOREC_MS 1200
`define AUTOREC_CYC ((`AUTOREC_MS * 1000000) / `CLK_PERIOD_NS)
// Valley timeout when no demagnetization is seen
`define VALLEY_TO_US 8
`define VALLEY_TO_CYC ((`VALLEY_TO_US * 1000) / `CLK_PERIOD_NS)
`define VALLEY_CNT_W 9
// Consecutive abnormal overcurrent events before latch
`define AOC_LIMIT 4
`define AOC_CNT_W 3
// Number of synchronised comparator inputs
`define SYNC_N 10

`endif

// [rtl/fault_sup_pkg.sv]
// Purpose: Types for the flyback fault supervisor
// Assumes: Nothing
// Notes: Constants live in fault_sup_params.svh
package fault_sup_pkg;
   typedef enum logic [1:0] {OVLD_LATCH, OVLD_AUTOREC, OVLD_NONE} ovld_mode_t;
   typedef enum logic [1:0] {ST_WAIT, ST_RUN, ST_AUTOREC, ST_LATCHED} sup_state_t;
endpackage : fault_sup_pkg

// [rtl/flyback_fault_supervisor.sv]
// Purpose: Fault supervisor of a quasi-resonant flyback controller
// Assumes: Comparator levels arrive asynchronously; thermal hysteresis is
//          resolved by the analog side into a separate clear level
// Notes: Overload action is chosen by the OVLD_MODE parameter
`include "fault_sup_params.svh"
`timescale 1ns/1ps
`default_nettype none
module flyback_fault_supervisor #(
   parameter fault_sup_pkg::ovld_mode_t OVLD_MODE = fault_sup_pkg::OVLD_LATCH,
   parameter int unsigned OVLD_CYCLES = `OVLD_CYC,
   parameter int unsigned AUTOREC_CYCLES = `AUTOREC_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic overload_in,
   input wire logic abnormal_current_cmp,
   input wire logic cs_peak_cmp,
   input wire logic cs_open_in,
   input wire logic zero_crossing_input,
   input wire logic supply_start_in,
   input wire logic supply_reset_in,
   input wire logic supply_overvoltage_in,
   input wire logic thermal_trip_in,
   input wire logic thermal_clear_in,
   output logic gate_drive_out,
   output logic running_out,
   output logic latched_fault_out,
   output logic autorec_active_out,
   output logic thermal_fault_out
);
   localparam int OW = $clog2(OVLD_CYCLES + 1);
   localparam int AW = $clog2(AUTOREC_CYCLES + 1);
   localparam logic [OW-1:0] OVLD_TOP = OW'(OVLD_CYCLES - 1);
   localparam logic [AW-1:0] AUTOREC_TOP = AW'(AUTOREC_CYCLES - 1);
   localparam logic [`VALLEY_CNT_W-1:0] VALLEY_TOP = `VALLEY_CNT_W'(`VALLEY_TO_CYC);
   localparam logic [`AOC_CNT_W-1:0] AOC_TOP = `AOC_CNT_W'(`AOC_LIMIT - 1);

   // Two-flop synchronisers, one per comparator level
   wire [`SYNC_N-1:0] raw_in = {overload_in, abnormal_current_cmp, cs_peak_cmp,
      cs_open_in, zero_crossing_input, supply_start_in, supply_reset_in,
      supply_overvoltage_in, thermal_trip_in, thermal_clear_in};
   logic [`SYNC_N-1:0] meta_ff;
   logic [`SYNC_N-1:0] sync_ff;

   genvar gi;
   generate
      for (gi = 0; gi < `SYNC_N; gi++) begin : g_sync
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               meta_ff[gi] <= 1'b0;
               sync_ff[gi] <= 1'b0;
            end else begin
               meta_ff[gi] <= raw_in[gi];
               sync_ff[gi] <= meta_ff[gi];
            end
         end
      end
   endgenerate

   wire ovld_s, aoc_s, peak_s, cs_open_s, zcd_s, start_s, reset_s, ovp_s;
   wire therm_s, therm_clr_s;
   assign {ovld_s, aoc_s, peak_s, cs_open_s, zcd_s, start_s, reset_s, ovp_s,
      therm_s, therm_clr_s} = sync_ff;

   pulse_if pif ();
   drive_pulse_timer u_pulse (
      .clk_sys(clk_sys),
      .rst(rst),
      .pif(pif)
   );

   fault_sup_pkg::sup_state_t state_ff;
   fault_sup_pkg::sup_state_t nxt_state;
   logic start_d_ff;
   logic zcd_d_ff;
   logic thermal_ff;
   logic trip_ff;
   logic [`AOC_CNT_W-1:0] aoc_cnt_ff;
   logic [OW-1:0] ovld_cnt_ff;
   logic [AW-1:0] ar_cnt_ff;
   logic [`VALLEY_CNT_W-1:0] valley_cnt_ff;
   logic running_ff;
   logic latched_ff;
   logic autorec_ff;

   // Decoding
   wire run = (state_ff == fault_sup_pkg::ST_RUN);
   wire supply_start_evt = start_s & ~start_d_ff;
   wire demag_evt = zcd_d_ff & ~zcd_s;
   wire abn_trip = aoc_s & pif.blank_done;
   wire pulse_tripped = trip_ff | abn_trip;
   wire aoc_latch = pif.pulse_end & pulse_tripped & (aoc_cnt_ff == AOC_TOP);
   wire ovld_enabled = (OVLD_MODE != fault_sup_pkg::OVLD_NONE);
   wire ovld_declare = ovld_enabled & run & ovld_s & (ovld_cnt_ff == OVLD_TOP);
   wire any_fault = thermal_ff | therm_s | ovp_s;
   wire valley_expired = (valley_cnt_ff == VALLEY_TOP);
   wire ar_expired = (ar_cnt_ff == AUTOREC_TOP);

   // Any fault or pulse end reason clears drive on the next edge
   assign pif.kill = ~run | ovp_s | therm_s | cs_open_s | abn_trip
      | (peak_s & pif.blank_done) | ovld_declare | aoc_latch;
   // Suppressed timeout means only demagnetization can start a pulse
   assign pif.start = run & ~pif.kill & ~pif.drive
      & (demag_evt | (valley_expired & ~zcd_s));

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         fault_sup_pkg::ST_WAIT: begin
            if (supply_start_evt & ~any_fault) begin
               nxt_state = fault_sup_pkg::ST_RUN;
            end
         end
         fault_sup_pkg::ST_RUN: begin
            if (aoc_latch) begin
               nxt_state = fault_sup_pkg::ST_LATCHED;
            end else if (therm_s) begin
               nxt_state = fault_sup_pkg::ST_WAIT;
            end else if (ovld_declare) begin
               if (OVLD_MODE == fault_sup_pkg::OVLD_LATCH) begin
                  nxt_state = fault_sup_pkg::ST_LATCHED;
               end else begin
                  nxt_state = fault_sup_pkg::ST_AUTOREC;
               end
            end
         end
         fault_sup_pkg::ST_AUTOREC: begin
            if (ar_expired) begin
               nxt_state = fault_sup_pkg::ST_WAIT;
            end
         end
         fault_sup_pkg::ST_LATCHED: begin
            nxt_state = fault_sup_pkg::ST_LATCHED;
         end
      endcase
      // Overvoltage latches from any state; supply reset beats everything
      if (ovp_s) begin
         nxt_state = fault_sup_pkg::ST_LATCHED;
      end
      if (reset_s) begin
         nxt_state = fault_sup_pkg::ST_WAIT;
      end
   end

   // Next values of counters and flags
   logic nxt_thermal;
   logic nxt_trip;
   logic [`AOC_CNT_W-1:0] nxt_aoc_cnt;
   logic [OW-1:0] nxt_ovld_cnt;
   logic [AW-1:0] nxt_ar_cnt;
   logic [`VALLEY_CNT_W-1:0] nxt_valley_cnt;

   // Trip sets win over clearing by a clean release
   assign nxt_thermal = therm_s | (thermal_ff & ~therm_clr_s & ~reset_s);
   assign nxt_trip = pif.start ? 1'b0 : pulse_tripped;
   assign nxt_aoc_cnt = (reset_s | aoc_latch) ? '0 :
      (pif.pulse_end ? (pulse_tripped ? aoc_cnt_ff + 1'b1 : '0) : aoc_cnt_ff);
   // Up/down integration floored at zero and cleared on declare, held outside run
   assign nxt_ovld_cnt = (~ovld_enabled | reset_s | ovld_declare) ? '0 :
      ~run ? ovld_cnt_ff :
      ovld_s ? ovld_cnt_ff + 1'b1 :
      (ovld_cnt_ff != '0) ? ovld_cnt_ff - 1'b1 : ovld_cnt_ff;
   assign nxt_ar_cnt = (state_ff == fault_sup_pkg::ST_AUTOREC) ?
      ar_cnt_ff + 1'b1 : '0;
   assign nxt_valley_cnt = (pif.drive | zcd_s | ~run) ? '0 :
      (valley_expired ? valley_cnt_ff : valley_cnt_ff + 1'b1);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_ff <= fault_sup_pkg::ST_WAIT;
         start_d_ff <= 1'b0;
         zcd_d_ff <= 1'b0;
         thermal_ff <= 1'b0;
         trip_ff <= 1'b0;
         aoc_cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         start_d_ff <= start_s;
         zcd_d_ff <= zcd_s;
         thermal_ff <= nxt_thermal;
         trip_ff <= nxt_trip;
         aoc_cnt_ff <= nxt_aoc_cnt;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ovld_cnt_ff <= '0;
         ar_cnt_ff <= '0;
         valley_cnt_ff <= '0;
      end else begin
         ovld_cnt_ff <= nxt_ovld_cnt;
         ar_cnt_ff <= nxt_ar_cnt;
         valley_cnt_ff <= nxt_valley_cnt;
      end
   end

   // Status outputs registered from the next state
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         running_ff <= 1'b0;
         latched_ff <= 1'b0;
         autorec_ff <= 1'b0;
      end else begin
         running_ff <= (nxt_state == fault_sup_pkg::ST_RUN);
         latched_ff <= (nxt_state == fault_sup_pkg::ST_LATCHED);
         autorec_ff <= (nxt_state == fault_sup_pkg::ST_AUTOREC);
      end
   end

   assign gate_drive_out = pif.drive;
   assign running_out = running_ff;
   assign latched_fault_out = latched_ff;
   assign autorec_active_out = autorec_ff;
   assign thermal_fault_out = thermal_ff;

   sequence s_tripped_end;
      pif.pulse_end && pulse_tripped;
   endsequence
   sequence s_clean_end;
      pif.pulse_end && !pulse_tripped;
   endsequence

   a_ovp_latch: assert property (@(posedge clk_sys) disable iff (rst)
      ovp_s && !reset_s |=> state_ff == fault_sup_pkg::ST_LATCHED && !gate_drive_out)
      else $error("overvoltage did not latch with drive off");
   a_aoc_latch: assert property (@(posedge clk_sys) disable iff (rst)
      s_tripped_end and (aoc_cnt_ff == AOC_TOP && run && !reset_s)
      |=> state_ff == fault_sup_pkg::ST_LATCHED)
      else $error("fourth abnormal overcurrent event did not latch");
   a_aoc_clear: assert property (@(posedge clk_sys) disable iff (rst)
      s_clean_end |=> aoc_cnt_ff == '0)
      else $error("clean pulse did not clear event counter");
   a_latch_hold: assert property (@(posedge clk_sys) disable iff (rst)
      state_ff == fault_sup_pkg::ST_LATCHED && !reset_s
      |=> state_ff == fault_sup_pkg::ST_LATCHED && !gate_drive_out)
      else $error("latched state left without supply reset");
   a_valley_held: assert property (@(posedge clk_sys) disable iff (rst)
      zcd_s |=> valley_cnt_ff == '0)
      else $error("valley timer ran while input armed");
   a_armed_wait: assert property (@(posedge clk_sys) disable iff (rst)
      pif.start && !demag_evt |-> !zcd_s && valley_expired)
      else $error("pulse started while timeout suppressed");
   a_cs_open_stop: assert property (@(posedge clk_sys) disable iff (rst)
      cs_open_s |-> !pif.start ##1 !gate_drive_out)
      else $error("switching with current sense open");
   a_clean_start: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(running_ff) |-> $past(supply_start_evt) && !$past(thermal_ff))
      else $error("start without supply event or with active fault");
   a_thermal_stop: assert property (@(posedge clk_sys) disable iff (rst)
      run && therm_s && !ovp_s && !aoc_latch && !reset_s
      |=> state_ff == fault_sup_pkg::ST_WAIT && thermal_fault_out)
      else $error("thermal trip did not stop the controller");
   a_thermal_hyst: assert property (@(posedge clk_sys) disable iff (rst)
      thermal_ff && !therm_clr_s && !reset_s |=> thermal_ff)
      else $error("thermal fault cleared before hysteresis");
   a_thermal_reset: assert property (@(posedge clk_sys) disable iff (rst)
      reset_s && !therm_s |=> !thermal_ff)
      else $error("supply reset left thermal fault pending");
   a_autorec_hold: assert property (@(posedge clk_sys) disable iff (rst)
      state_ff == fault_sup_pkg::ST_AUTOREC && !ar_expired && !reset_s && !ovp_s
      |=> state_ff == fault_sup_pkg::ST_AUTOREC && !gate_drive_out)
      else $error("auto-recovery left before timer expiry");
   a_ovld_action: assert property (@(posedge clk_sys) disable iff (rst)
      ovld_declare && !aoc_latch && !therm_s && !ovp_s && !reset_s
      |=> state_ff == (OVLD_MODE == fault_sup_pkg::OVLD_LATCH ?
         fault_sup_pkg::ST_LATCHED : fault_sup_pkg::ST_AUTOREC))
      else $error("overload declared without its action");
   a_ovld_integ: assert property (@(posedge clk_sys) disable iff (rst)
      run && !ovld_s && ovld_cnt_ff != '0 && !reset_s && ovld_enabled
      |=> ovld_cnt_ff == $past(ovld_cnt_ff) - 1'b1)
      else $error("overload integrator did not count down");
endmodule : flyback_fault_supervisor
`default_nettype wire

// [rtl/pulse_if.sv]
// Purpose: Link between supervisor and its drive pulse timer
// Assumes: One clock
// Notes: kill has priority over start
`timescale 1ns/1ps
`default_nettype none
interface pulse_if;
   logic start;
   logic kill;
   logic drive;
   logic blank_done;
   logic pulse_end;
   modport drv (input start, input kill, output drive, output blank_done, output pulse_end);
   modport ctl (output start, output kill, input drive, input blank_done, input pulse_end);
endinterface : pulse_if
`default_nettype wire

// [tb/switch_model.sv]
// Purpose: Behavioural power switch and transformer behind the gate drive
// Assumes: Cycle-level timing on the system clock
// Notes: The demagnetization event is the fall of zc after the off-time delay
`timescale 1ns/1ps
`default_nettype none
module switch_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic gate_drive_out,
   input wire logic [7:0] peak_delay,
   input wire logic [7:0] demag_delay,
   input wire logic hold_zc,
   output logic cs_peak_cmp,
   output logic zero_crossing_input
);
   logic [10:0] on_cnt_ff;
   logic [7:0] off_cnt_ff;
   wire logic peak_reached;
   // Zero delay stands for a shorted sense pin: the comparator never trips
   assign peak_reached = (peak_delay != 8'h00) && (on_cnt_ff >= {3'h0, peak_delay});
   assign cs_peak_cmp = gate_drive_out && peak_reached;
   // Held high models leakage ringing that keeps the zero-crossing input armed
   assign zero_crossing_input = hold_zc || (!gate_drive_out && (off_cnt_ff != 8'h00));
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         on_cnt_ff <= 11'h000;
         off_cnt_ff <= 8'h00;
      end else if (gate_drive_out) begin
         on_cnt_ff <= on_cnt_ff + 11'h001;
         off_cnt_ff <= demag_delay;
      end else begin
         on_cnt_ff <= 11'h000;
         if (off_cnt_ff != 8'h00) off_cnt_ff <= off_cnt_ff - 8'h01;
      end
   end
endmodule : switch_model
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench for the flyback fault supervisor
// Assumes: Short overload and auto-recovery counts set by parameter
// Notes: One instance per overload variant; the switch model follows i_dut
`include "fault_sup_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [3:0] S_OFF = 4'h0, S_RUN = 4'h8, S_LAT = 4'h4, S_HOT = 4'h1;
   logic clk_sys, rst, overload_in, abnormal_current_cmp, cs_open_in, supply_start_in;
   logic supply_reset_in, supply_overvoltage_in, thermal_trip_in, thermal_clear_in, hold_zc;
   logic cs_peak_cmp, zero_crossing_input, gate_drive_out, running_out, latched_fault_out;
   logic autorec_active_out, thermal_fault_out, auto_run, auto_wait, none_run;
   logic [7:0] peak_delay, demag_delay;
   logic [3:0] status_q[$];
   int width_q[$];
   int num_errors, checks_done, last_w;
   wire logic [3:0] status;
   assign status = {running_out, latched_fault_out, autorec_active_out, thermal_fault_out};

   flyback_fault_supervisor #(.OVLD_MODE(fault_sup_pkg::OVLD_LATCH), .OVLD_CYCLES(50),
      .AUTOREC_CYCLES(40)) i_dut (
      .clk_sys(clk_sys), .rst(rst), .overload_in(overload_in),
      .abnormal_current_cmp(abnormal_current_cmp), .cs_peak_cmp(cs_peak_cmp),
      .cs_open_in(cs_open_in), .zero_crossing_input(zero_crossing_input),
      .supply_start_in(supply_start_in), .supply_reset_in(supply_reset_in),
      .supply_overvoltage_in(supply_overvoltage_in), .thermal_trip_in(thermal_trip_in),
      .thermal_clear_in(thermal_clear_in), .gate_drive_out(gate_drive_out),
      .running_out(running_out), .latched_fault_out(latched_fault_out),
      .autorec_active_out(autorec_active_out), .thermal_fault_out(thermal_fault_out));
   flyback_fault_supervisor #(.OVLD_MODE(fault_sup_pkg::OVLD_AUTOREC), .OVLD_CYCLES(50),
      .AUTOREC_CYCLES(40)) i_auto (
      .clk_sys(clk_sys), .rst(rst), .overload_in(overload_in),
      .abnormal_current_cmp(abnormal_current_cmp), .cs_peak_cmp(cs_peak_cmp),
      .cs_open_in(cs_open_in), .zero_crossing_input(zero_crossing_input),
      .supply_start_in(supply_start_in), .supply_reset_in(supply_reset_in),
      .supply_overvoltage_in(supply_overvoltage_in), .thermal_trip_in(thermal_trip_in),
      .thermal_clear_in(thermal_clear_in), .gate_drive_out(), .running_out(auto_run),
      .latched_fault_out(), .autorec_active_out(auto_wait), .thermal_fault_out());
   // No auto-recovery wait is reachable here, so the default wait length stays
   flyback_fault_supervisor #(.OVLD_MODE(fault_sup_pkg::OVLD_NONE), .OVLD_CYCLES(50))
      i_none (
      .clk_sys(clk_sys), .rst(rst), .overload_in(overload_in),
      .abnormal_current_cmp(abnormal_current_cmp), .cs_peak_cmp(cs_peak_cmp),
      .cs_open_in(cs_open_in), .zero_crossing_input(zero_crossing_input),
      .supply_start_in(supply_start_in), .supply_reset_in(supply_reset_in),
      .supply_overvoltage_in(supply_overvoltage_in), .thermal_trip_in(thermal_trip_in),
      .thermal_clear_in(thermal_clear_in), .gate_drive_out(), .running_out(none_run),
      .latched_fault_out(), .autorec_active_out(), .thermal_fault_out());
   switch_model i_switch (.clk_sys(clk_sys), .rst(rst), .gate_drive_out(gate_drive_out),
      .peak_delay(peak_delay), .demag_delay(demag_delay), .hold_zc(hold_zc),
      .cs_peak_cmp(cs_peak_cmp), .zero_crossing_input(zero_crossing_input));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic step(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : step

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   // A missing pulse is fatal, the bound then ends the run
   task automatic wait_drive(input logic lvl, input int bound, input logic want);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < bound && !seen; i++) begin
         step(1);
         seen = (gate_drive_out === lvl);
      end
      check(16'(seen), 16'(want), "gate drive level");
      if (want && !seen) print_verdict();
   endtask : wait_drive

   task automatic settle();
      for (int i = 0; i < 3000 && status_q.size() != 0; i++) step(1);
      if (status_q.size() != 0) begin
         num_errors++;
         $display("CHECK FAILED at %0t: state change never came", $time);
         print_verdict();
      end
      step(6);
   endtask : settle

   task automatic restart();
      supply_start_in = 1'b0;
      step(4);
      supply_start_in = 1'b1;
   endtask : restart

   task automatic power_cycle();
      status_q.push_back(S_OFF);
      supply_reset_in = 1'b1;
      step(4);
      supply_reset_in = 1'b0;
      settle();
      status_q.push_back(S_RUN);
      restart();
      settle();
   endtask : power_cycle

   // Merges transitions that land up to three cycles apart, then compares the settled state
   initial begin : monitor
      logic [3:0] last;
      int on_len;
      last = S_OFF;
      on_len = 0;
      forever begin
         @(posedge clk_sys);
         #1;
         if (gate_drive_out === 1'b1) begin
            on_len++;
         end else if (on_len != 0) begin
            last_w = on_len;
            on_len = 0;
            if (width_q.size() != 0) check(16'(last_w), 16'(width_q.pop_front()), "width");
         end
         if (rst) begin
            last = S_OFF;
         end else if (status !== last) begin
            repeat (3) @(posedge clk_sys);
            #1;
            last = status;
            if (status_q.size() == 0) check(16'(last), 16'hffff, "unexpected state");
            else check(16'(last), 16'(status_q.pop_front()), "state");
         end
      end
   end

   initial begin
      rst = 1'b1;
      {overload_in, abnormal_current_cmp, cs_open_in, supply_start_in, supply_reset_in} = 5'h00;
      {supply_overvoltage_in, thermal_trip_in, thermal_clear_in, hold_zc} = 4'h0;
      {num_errors, checks_done, last_w} = {32'h0, 32'h0, 32'h0};
      peak_delay = 8'h00;
      demag_delay = 8'h06;
      void'($urandom(32'h8e5b));
      step(10);
      rst = 1'b0;
      status_q.push_back(S_RUN);
      supply_start_in = 1'b1;
      settle();
      width_q.push_back(`MAX_ON_CYC);
      wait_drive(1'b1, 1000, 1'b1);
      wait_drive(1'b0, 2000, 1'b1);
      for (int i = 0; i < 6; i++) begin
         peak_delay = 8'(20 + $urandom_range(40));
         demag_delay = 8'(6 + $urandom_range(10));
         wait_drive(1'b1, 1000, 1'b1);
         wait_drive(1'b0, 200, 1'b1);
      end
      cs_open_in = 1'b1;
      wait_drive(1'b1, 600, 1'b0);
      cs_open_in = 1'b0;
      wait_drive(1'b1, 600, 1'b1);
      wait_drive(1'b0, 200, 1'b1);
      hold_zc = 1'b1;
      wait_drive(1'b1, 600, 1'b0);
      hold_zc = 1'b0;
      wait_drive(1'b1, 20, 1'b1);
      // Net integration stays below full scale unless the count fails to fall
      overload_in = 1'b1;
      step(30);
      overload_in = 1'b0;
      step(30);
      overload_in = 1'b1;
      step(40);
      status_q.push_back(S_LAT);
      settle();
      overload_in = 1'b0;
      check(16'({auto_run, auto_wait, none_run}), 16'h3, "overload variants");
      step(45);
      check(16'({auto_run, auto_wait}), 16'h0, "auto-recovery expiry");
      restart();
      step(8);
      check(16'({auto_run, none_run}), 16'h3, "restart after expiry");
      power_cycle();
      // Three trips, a clean pulse, then four trips: only the last may latch
      for (int i = 0; i < 8; i++) begin
         wait_drive(1'b0, 2000, 1'b1);
         abnormal_current_cmp = (i != 3);
         if (i == 7) status_q.push_back(S_LAT);
         if (i == 7) break;
         wait_drive(1'b1, 1000, 1'b1);
         wait_drive(1'b0, 2000, 1'b1);
         if (i != 3) check(16'(last_w > 6), 16'h1, "blanking");
      end
      wait_drive(1'b1, 1000, 1'b1);
      settle();
      abnormal_current_cmp = 1'b0;
      power_cycle();
      wait_drive(1'b1, 1000, 1'b1);
      supply_overvoltage_in = 1'b1;
      status_q.push_back(S_LAT);
      wait_drive(1'b0, 4, 1'b1);
      settle();
      supply_overvoltage_in = 1'b0;
      power_cycle();
      thermal_trip_in = 1'b1;
      status_q.push_back(S_HOT);
      settle();
      thermal_trip_in = 1'b0;
      restart();
      step(8);
      thermal_clear_in = 1'b1;
      status_q.push_back(S_OFF);
      settle();
      thermal_clear_in = 1'b0;
      status_q.push_back(S_RUN);
      restart();
      settle();
      thermal_trip_in = 1'b1;
      status_q.push_back(S_HOT);
      settle();
      thermal_trip_in = 1'b0;
      power_cycle();
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
